// ===== rtl/spi_buf.sv
// Functional notes
// - buffer mode: receive flag set while bytes unread, clears when empty or on write-one
// - buffer mode: transfer flag set when shifter empties with no new byte buffered; write-one clears
// - transmit-empty flag reads one when buffer empty, zero while holding a byte
// - writing data in buffer mode clears the transmit-empty flag
// - takeover flag set when host select pin driven low, unless select disabled
// - overflow set when two bytes buffered and a third completes
// - with no transmit data, overflow waits until the next transfer starts
// - overflow cleared by data read or write-one
// - host: data write starts transfer; client: write only stages the byte
// - normal mode: write loads shifter, read returns receive data register
// - buffer mode: write fills transmit buffer, read pops buffer and advances
// - buffer mode only when buffer enable is one
// - select pin low in host operation clears host select, unless select disabled
`include "spi_buf_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_buf
  import spi_buf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] SCK_HALF = 8'h04
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire spi_in_s spi_in,
  output spi_out_s spi_out,
  output logic irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic enable;
    logic host;
    logic buffer_mode_enable;
    logic select_line_disable;
    logic [7:0] mask;
    logic rxc;
    logic txc;
    logic ssf;
    logic ovf;
    logic ovf_pend;
    logic [7:0] txb;
    logic txb_v;
    logic [7:0] rxb0;
    logic [7:0] rxb1;
    logic [1:0] rxn;
    logic [7:0] rdr;
    logic rdr_v;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ph;
    logic sck;
    logic smp;
    eng_e eng;
    spi_in_s s1;
    spi_in_s s2;
    spi_in_s s3;
    logic irq;
  } state_s;

  state_s st_q;
  state_s st_d;

  // word-aligned and inside the map
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(`REG_IDX_DATA));
  endfunction

  function automatic logic [5:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = 6'(a[ADDR_W-1:2]);
  endfunction

  function automatic logic [7:0] flags_of(input state_s s);
    flags_of = `RESET_BYTE;
    flags_of[`BIT_RX_COMPLETE] = s.rxc;
    flags_of[`BIT_TRANSFER_COMPLETE] = s.txc;
    flags_of[`BIT_TX_EMPTY] = !s.txb_v;
    flags_of[`BIT_SELECT_TAKEOVER] = s.ssf;
    flags_of[`BIT_OVERFLOW] = s.ovf;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic do_write;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic rise;
    logic xfer_start;
    logic done;
    logic go;
    logic [7:0] fl;
    do_write = 1'b0;
    widx = 6'h00;
    ridx = 6'h00;
    rise = 1'b0;
    xfer_start = 1'b0;
    done = 1'b0;
    go = 1'b0;
    fl = `RESET_BYTE;
    st_d = st_q;

    // pins pass two flops; s3 only serves edge detection
    st_d.s1 = spi_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    rise = st_q.s2.sck && !st_q.s3.sck;

    // ---- write channel: address and data taken in either order
    if (awvalid && st_q.awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && st_q.wready) begin
      st_d.w_got = 1'b1;
      st_d.w_byte = wdata[7:0];
      st_d.w_lane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = addr_ok(st_q.aw_addr) ? `AXI_OKAY : `AXI_SLVERR;
      do_write = addr_ok(st_q.aw_addr) && st_q.w_lane0;
      widx = addr_idx(st_q.aw_addr);
    end

    if (do_write) begin
      case (widx)
        `REG_IDX_CTRL_A: begin
          st_d.enable = st_q.w_byte[`BIT_ENABLE];
          st_d.host = st_q.w_byte[`BIT_HOST_SELECT];
        end
        `REG_IDX_CTRL_B: begin
          st_d.buffer_mode_enable = st_q.w_byte[`BIT_BUFFER_MODE_ENABLE];
          st_d.select_line_disable = st_q.w_byte[`BIT_SELECT_LINE_DISABLE];
        end
        `REG_IDX_IRQ_MASK: st_d.mask = st_q.w_byte;
        `REG_IDX_FLAGS: begin
          if (st_q.w_byte[`BIT_RX_COMPLETE]) st_d.rxc = 1'b0;
          if (st_q.w_byte[`BIT_TRANSFER_COMPLETE]) st_d.txc = 1'b0;
          if (st_q.w_byte[`BIT_SELECT_TAKEOVER]) st_d.ssf = 1'b0;
          if (st_q.w_byte[`BIT_OVERFLOW]) st_d.ovf = 1'b0;
        end
        `REG_IDX_DATA: begin
          if (st_q.buffer_mode_enable) begin
            // fill transmit buffer, empty flag drops
            st_d.txb = st_q.w_byte;
            st_d.txb_v = 1'b1;
          end else if (st_q.eng == ENG_IDLE && st_q.cnt == 4'h0) begin
            // load shifter directly; busy writes are dropped
            st_d.sh = st_q.w_byte;
            go = st_q.host;
          end
        end
        default: ;
      endcase
    end

    // ---- read channel
    if (rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && st_q.arready) begin
      ridx = addr_idx(araddr);
      st_d.rvalid = 1'b1;
      st_d.rresp = addr_ok(araddr) ? `AXI_OKAY : `AXI_SLVERR;
      st_d.rdata = 32'h0000_0000;
      fl = flags_of(st_q);
      if (addr_ok(araddr)) begin
        case (ridx)
          `REG_IDX_CTRL_A: begin
            st_d.rdata[`BIT_ENABLE] = st_q.enable;
            st_d.rdata[`BIT_HOST_SELECT] = st_q.host;
          end
          `REG_IDX_CTRL_B: begin
            st_d.rdata[`BIT_BUFFER_MODE_ENABLE] = st_q.buffer_mode_enable;
            st_d.rdata[`BIT_SELECT_LINE_DISABLE] = st_q.select_line_disable;
          end
          `REG_IDX_IRQ_MASK: st_d.rdata[7:0] = st_q.mask;
          `REG_IDX_FLAGS: st_d.rdata[7:0] = fl;
          `REG_IDX_DATA: begin
            st_d.ovf = 1'b0;
            if (st_q.buffer_mode_enable) begin
              // oldest byte out, receive data register moves up
              st_d.rdata[7:0] = st_q.rxb0;
              if (st_q.rxn != 2'h0) begin
                st_d.rxb0 = st_q.rxb1;
                if (st_q.rdr_v && st_q.rxn == `RX_DEPTH) begin
                  st_d.rxb1 = st_q.rdr;
                  st_d.rdr_v = 1'b0;
                end else begin
                  st_d.rxn = st_q.rxn - 2'h1;
                end
                if (st_q.rxn == 2'h1 && !(st_q.rdr_v)) st_d.rxc = 1'b0;
              end
            end else begin
              st_d.rdata[7:0] = st_q.rdr;
            end
          end
          default: ;
        endcase
      end
    end

    // ---- shift engine, mode 0, msb first
    // a client keeps the byte staged until its host selects it
    if (st_q.buffer_mode_enable && st_q.eng == ENG_IDLE && st_q.cnt == 4'h0 && st_q.txb_v && (st_q.host || !st_q.s2.ss_n)) begin
      // byte leaves buffer, empty flag rises
      st_d.sh = st_q.txb;
      st_d.txb_v = 1'b0;
      // host starts from the buffer, client waits for its host
      go = st_q.host;
    end
    if (!st_q.enable) begin
      st_d.eng = ENG_IDLE;
      st_d.sck = 1'b0;
      st_d.cnt = 4'h0;
    end else if (st_q.host) begin
      case (st_q.eng)
        ENG_IDLE: begin
          if (go) begin
            st_d.eng = ENG_RUN;
            st_d.ph = 8'h00;
            st_d.cnt = 4'h0;
            st_d.sck = 1'b0;
            xfer_start = 1'b1;
          end
        end
        ENG_RUN: begin
          if (st_q.ph == SCK_HALF - 8'h01) begin
            st_d.ph = 8'h00;
            // sample on the rise, shift on the fall, so data never moves with a rising edge
            if (!st_q.sck) begin
              st_d.sck = 1'b1;
              st_d.smp = st_q.s2.cipo;
              st_d.cnt = st_q.cnt + 4'h1;
            end else begin
              st_d.sck = 1'b0;
              st_d.sh = {st_d.sh[6:0], st_q.smp};
              if (st_q.cnt == `BITS_PER_BYTE) begin
                st_d.eng = ENG_IDLE;
                st_d.cnt = 4'h0;
                done = 1'b1;
              end
            end
          end else begin
            st_d.ph = st_q.ph + 8'h01;
          end
        end
        default: st_d.eng = ENG_IDLE;
      endcase
    end else begin
      st_d.eng = ENG_IDLE;
      st_d.sck = 1'b0;
      if (st_q.s2.ss_n) begin
        st_d.cnt = 4'h0;
      end else if (rise) begin
        xfer_start = (st_q.cnt == 4'h0);
        st_d.sh = {st_d.sh[6:0], st_q.s2.copi};
        st_d.cnt = st_q.cnt + 4'h1;
        if (st_q.cnt == `BITS_PER_BYTE - 4'h1) begin
          st_d.cnt = 4'h0;
          done = 1'b1;
        end
      end
    end

    // deferred overflow lands at the next transfer start
    if (xfer_start && st_q.ovf_pend) begin
      st_d.ovf = 1'b1;
      st_d.ovf_pend = 1'b0;
    end

    // ---- byte completion; sets come after clears so they win
    if (done) begin
      if (!st_q.buffer_mode_enable) begin
        st_d.rdr = st_d.sh;
        st_d.rxc = 1'b1;
      end else begin
        st_d.rxc = 1'b1;
        if (st_d.rxn == 2'h0) begin
          st_d.rxb0 = st_d.sh;
          st_d.rxn = 2'h1;
        end else if (st_d.rxn == 2'h1) begin
          st_d.rxb1 = st_d.sh;
          st_d.rxn = `RX_DEPTH;
        end else begin
          // third byte on a full buffer
          st_d.rdr = st_d.sh;
          st_d.rdr_v = 1'b1;
          if (st_d.txb_v) st_d.ovf = 1'b1;
          else st_d.ovf_pend = 1'b1;
        end
        if (!st_d.txb_v) st_d.txc = 1'b1;
      end
    end

    // external select low forces client operation unless the select line is disabled
    if (st_q.enable && st_q.host && !st_q.select_line_disable && !st_q.s2.ss_n) begin
      st_d.host = 1'b0;
      st_d.ssf = 1'b1;
      st_d.eng = ENG_IDLE;
      st_d.sck = 1'b0;
      st_d.cnt = 4'h0;
    end

    // buffer-only flags stay quiet in normal mode
    if (!st_d.buffer_mode_enable) begin
      st_d.txc = 1'b0;
      st_d.ovf_pend = 1'b0;
    end

    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready = !st_d.w_got && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
    // level interrupt from unmasked flags
    st_d.irq = |(flags_of(st_d) & st_d.mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.s1 <= 4'hf;
      st_q.s2 <= 4'hf;
      st_q.s3 <= 4'hf;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs from flops; the three drive enables are ANDs of flops
  // ****************************************
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rresp = st_q.rresp;
  assign rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign spi_out.sck = st_q.sck;
  assign spi_out.sck_oe = st_q.enable & st_q.host;
  assign spi_out.copi = st_q.sh[7];
  assign spi_out.copi_oe = st_q.enable & st_q.host;
  assign spi_out.cipo = st_q.sh[7];
  // miso only driven while selected, so several clients can share it
  assign spi_out.cipo_oe = st_q.enable & !st_q.host & !st_q.s2.ss_n;

endmodule // spi_buf

`default_nettype wire

// ===== rtl/spi_buf_consts.svh
`ifndef SPI_BUF_CONSTS_SVH
`define SPI_BUF_CONSTS_SVH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define REG_IDX_CTRL_A 6'h00
`define REG_IDX_CTRL_B 6'h01
`define REG_IDX_IRQ_MASK 6'h02
`define REG_IDX_FLAGS 6'h03
`define REG_IDX_DATA 6'h04

// ****************************************
// field positions
// ****************************************
`define BIT_ENABLE 0
`define BIT_HOST_SELECT 5
`define BIT_BUFFER_MODE_ENABLE 7
`define BIT_SELECT_LINE_DISABLE 2
`define BIT_RX_COMPLETE 7
`define BIT_TRANSFER_COMPLETE 6
`define BIT_TX_EMPTY 5
`define BIT_SELECT_TAKEOVER 4
`define BIT_OVERFLOW 0

// ****************************************
// reset values and timing
// ****************************************
`define RESET_BYTE 8'h00
`define BITS_PER_BYTE 4'h8
`define RX_DEPTH 2'h2
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ===== rtl/spi_buf_pkg.sv
package spi_buf_pkg;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } eng_e;

  typedef struct packed {
    logic sck;
    logic copi;
    logic cipo;
    logic ss_n;
  } spi_in_s;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic copi;
    logic copi_oe;
    logic cipo;
    logic cipo_oe;
  } spi_out_s;

endpackage

// ===== tb/spi_buf_bench.sv
`include "spi_buf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_buf_bench
  import spi_buf_pkg::*;
;
  // ********
  // bench
  // ********
  localparam logic [7:0] CA = {`REG_IDX_CTRL_A, 2'b00};
  localparam logic [7:0] CB = {`REG_IDX_CTRL_B, 2'b00};
  localparam logic [7:0] MK = {`REG_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] FL = {`REG_IDX_FLAGS, 2'b00};
  localparam logic [7:0] DT = {`REG_IDX_DATA, 2'b00};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rq;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rs = 32'hbca2;
  logic [7:0] b [3];
  spi_in_s spi_in;
  spi_out_s spi_out;
  int num_errors = 0;
  int cmp_count = 0;
  int i, n;
  spi_buf u_spi_buf (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .spi_in, .spi_out, .irq);
  spi_peer u_spi_peer (.so(spi_out), .si(spi_in));
  always #50 mclk = ~mclk;
  function automatic logic [31:0] lf(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one bus cycle; answer waited for, never assumed
  task automatic bus(bit w, logic [7:0] a, logic [7:0] d);
    int c;
    @(posedge mclk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h0, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (c = 0; c < 99; c++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (w ? bvalid : rvalid) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    rq = rdata[7:0];
    rsp = w ? bresp : rresp;
    if (c == 99) begin
      num_errors++;
      finish_test;
    end
  endtask
  task automatic fl(int p, logic e);
    bus(1'b0, FL, 8'h00);
    chk({7'h0, rq[p]}, {7'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, FL, 8'h00);
    chk(rq, 8'h20);
    bus(1'b0, DT, 8'h00);
    chk(rq, `RESET_BYTE);
    bus(1'b0, 8'h3c, 8'h00);
    chk({6'h0, rsp}, {6'h0, `AXI_SLVERR});
    bus(1'b1, 8'h40, 8'h00);
    chk({6'h0, rsp}, {6'h0, `AXI_SLVERR});
    $display("reset test done");
    bus(1'b1, CA, 8'h21);
    u_spi_peer.sel_pulse;
    fl(`BIT_SELECT_TAKEOVER, 1'b1);
    bus(1'b0, CA, 8'h00);
    chk(rq, 8'h01);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, MK, 8'h10);
    repeat (2) @(posedge mclk);
    chk({7'h0, irq}, 8'h01);
    bus(1'b1, FL, 8'h10);
    repeat (2) @(posedge mclk);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, CB, 8'h04);
    bus(1'b1, CA, 8'h21);
    u_spi_peer.sel_pulse;
    fl(`BIT_SELECT_TAKEOVER, 1'b0);
    bus(1'b0, CA, 8'h00);
    chk(rq, 8'h21);
    $display("takeover test done");
    bus(1'b1, MK, 8'h80);
    for (i = 0; i < 3; i++) begin
      u_spi_peer.rep <= rs[15:8];
      bus(1'b1, DT, rs[7:0]);
      for (n = 0; n < 999 && irq !== 1'b1; n++) @(posedge mclk);
      if (n == 999) begin
        num_errors++;
        finish_test;
      end
      chk(u_spi_peer.got, rs[7:0]);
      // data read inside the handler
      bus(1'b0, DT, 8'h00);
      chk(rq, rs[15:8]);
      bus(1'b1, FL, 8'h80);
      rs = lf(rs);
    end
    $display("host test done");
    bus(1'b1, CA, 8'h00);
    bus(1'b1, CB, 8'h80);
    bus(1'b1, CA, 8'h01);
    for (i = 0; i < 7; i++) begin
      if (i < 6) b[i % 3] = rs[7:0];
      u_spi_peer.host_xfer(rs[7:0]);
      rs = lf(rs);
      if (i == 2) begin
        fl(`BIT_OVERFLOW, 1'b0);
        fl(`BIT_RX_COMPLETE, 1'b1);
        for (n = 0; n < 3; n++) begin
          bus(1'b0, DT, 8'h00);
          chk(rq, b[n]);
        end
        fl(`BIT_RX_COMPLETE, 1'b0);
      end
    end
    fl(`BIT_OVERFLOW, 1'b1);
    bus(1'b0, DT, 8'h00);
    chk(rq, b[0]);
    fl(`BIT_OVERFLOW, 1'b0);
    bus(1'b1, FL, 8'h41);
    fl(`BIT_TRANSFER_COMPLETE, 1'b0);
    bus(1'b1, DT, rs[7:0]);
    fl(`BIT_TX_EMPTY, 1'b0);
    u_spi_peer.host_xfer(8'h00);
    chk(u_spi_peer.cap, rs[7:0]);
    u_spi_peer.host_xfer(8'h00);
    fl(`BIT_TX_EMPTY, 1'b1);
    fl(`BIT_TRANSFER_COMPLETE, 1'b1);
    bus(1'b1, FL, 8'h40);
    fl(`BIT_TRANSFER_COMPLETE, 1'b0);
    $display("buffer test done");
    finish_test;
  end
endmodule // spi_buf_bench
`default_nettype wire

// ===== tb/spi_buf_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checker
// ********
module spi_buf_sva
  import spi_buf_pkg::*;
#(
  parameter logic [7:0] SCK_HALF = 8'h04
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire spi_in_s spi_in,
  input wire spi_out_s spi_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // high run of host clock, judged at each fall
  logic [7:0] hc_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      hc_q <= 8'h00;
    else
      hc_q <= spi_out.sck ? hc_q + 8'h01 : 8'h00;
  end
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:2] bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_take |=> rvalid)
    else $error("read answer late");
  rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper lanes set");
  wr_refuse_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken early");
  rd_refuse_a: assert property (rvalid |-> !arready)
    else $error("read taken early");
  sck_half_a: assert property ($fell(spi_out.sck) |-> hc_q == SCK_HALF)
    else $error("clock high time wrong");
  copi_hold_a: assert property (spi_out.sck && $past(spi_out.sck) |-> $stable(spi_out.copi))
    else $error("data moved in high phase");
  role_excl_a: assert property (!(spi_out.copi_oe && spi_out.cipo_oe))
    else $error("both roles drive");
  cipo_free_a: assert property ($rose(spi_in.ss_n) |-> ##[1:5] !spi_out.cipo_oe)
    else $error("client line held");
endmodule // spi_buf_sva
bind spi_buf spi_buf_sva #(.SCK_HALF(SCK_HALF)) u_spi_buf_sva (.mclk, .reset, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid, .rdata, .spi_in, .spi_out);
`default_nettype wire

// ===== tb/spi_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// serial peer, client or host
// ********
module spi_peer
  import spi_buf_pkg::*;
(
  input wire spi_out_s so,
  output var spi_in_s si
);
  logic [7:0] rep = 8'h00;
  logic [7:0] got = 8'h00;
  logic [2:0] k = 3'h0;
  logic [7:0] cap = 8'h00;
  // clock stands low outside frames
  initial begin
    si.sck = 1'b0;
    si.copi = 1'b0;
    si.ss_n = 1'b1;
  end
  always @(posedge so.sck) if (so.copi_oe) got <= {got[6:0], so.copi};
  always @(negedge so.sck) if (so.copi_oe) k <= k + 3'h1;
  always @(posedge si.sck) if (so.cipo_oe) cap <= {cap[6:0], so.cipo};
  always @* si.cipo = rep[~k];
  task automatic host_xfer(input logic [7:0] tx);
    // step off the mclk edge so pins never change as they are sampled
    #20;
    si.ss_n = 1'b0;
    for (int j = 7; j >= 0; j--) begin
      si.copi = tx[j];
      #400 si.sck = 1'b1;
      #400 si.sck = 1'b0;
    end
    // released line shows no stale bit
    #400 si.copi = ~si.copi;
    si.ss_n = 1'b1;
    // gap between frames; the task lasts whole clock periods
    #380;
  endtask
  task automatic sel_pulse;
    #20;
    si.ss_n = 1'b0;
    #2000 si.ss_n = 1'b1;
    #400;
  endtask
endmodule // spi_peer
`default_nettype wire
